// ---- hw/rtc_calendar.v ----
// bcd clock/calendar with square-wave output and backed storage, axi4-lite slave
//
// How it works
// - seconds to year counters kept in bcd
// - date wraps per month length, february leap
// - hours count 24-hour or 12-hour with am/pm
// - year multiple of four is leap year
// - square wave gated by enable, four rates
// - fifty-six bytes of host storage
// - on battery, counters keep running, writes refused
// - oscillator stop bit halts the oscillator
// - time 00-06, control 07, storage 08-3f
// - six index bits from address bits 7:2, each access carries its own address
// - rate code 00..11 maps 1 hz..32.768 khz
// - disabled square wave drives level bit
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defs.vh"
module rtc_calendar #(
	parameter DIV_BITS = `RTC_DIV_BITS
) (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        crystal_in,
	input  wire        main_power_good,
	output reg         square_wave_out_pin,
	output reg         on_battery
);
	reg  [7:0]          sec_reg, min_reg, hour_reg, dow_reg, date_reg, month_reg, year_reg;
	reg  [7:0]          ctrl_reg;
	reg  [7:0]          ram_reg [0:`RTC_RAM_DEPTH-1];
	reg                 xtal_s1, xtal_s2, xtal_s3;
	reg                 pwr_s1, pwr_s2;
	reg  [DIV_BITS-1:0] pre_reg;
	reg                 tick_pending_reg;
	reg  [5:0]          aw_idx_reg;
	reg                 aw_held_reg;
	reg  [7:0]          w_data_reg;
	reg                 w_held_reg;
	reg                 w_lane_reg;
	reg  [7:0]          rd_byte;
	reg  [7:0]          date_max;
	reg  [7:0]          hour_next;
	reg                 hour_wrap;
	reg                 leap;
	reg                 sq_wave;
	integer             i;

	wire       oscillator_stop_bit    = sec_reg[`RTC_SEC_OSC_STOP];
	wire       square_wave_enable_bit = ctrl_reg[`RTC_CTRL_SQ_EN];
	wire       rate_select_hi         = ctrl_reg[`RTC_CTRL_RS_HI];
	wire       rate_select_lo         = ctrl_reg[`RTC_CTRL_RS_LO];
	wire       xtal_rise              = xtal_s2 & ~xtal_s3;
	wire       pre_full               = &pre_reg;
	wire       tick                   = xtal_rise & ~oscillator_stop_bit & pre_full;
	wire       do_write               = aw_held_reg & w_held_reg & ~s_axi_bvalid;
	wire       write_ok               = do_write & ~on_battery & w_lane_reg;
	wire       advance                = tick_pending_reg & ~do_write;
	wire [5:0] ar_idx                 = s_axi_araddr[7:2];
	wire [5:0] ram_rd_idx             = ar_idx - `RTC_IDX_RAM_FIRST;
	wire [5:0] ram_wr_idx             = aw_idx_reg - `RTC_IDX_RAM_FIRST;

	wire [7:0] sec_next, min_next, date_next, month_next, year_next, dow_next;
	wire       sec_wrap, min_wrap, date_wrap, month_wrap;

	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	bcd_step u_sec (.value({1'b0, sec_reg[6:0]}), .max_value(8'h59), .min_value(8'h00),
		.next_value(sec_next), .wrap(sec_wrap));
	bcd_step u_min (.value(min_reg), .max_value(8'h59), .min_value(8'h00),
		.next_value(min_next), .wrap(min_wrap));
	bcd_step u_date (.value(date_reg), .max_value(date_max), .min_value(8'h01),
		.next_value(date_next), .wrap(date_wrap));
	bcd_step u_month (.value(month_reg), .max_value(8'h12), .min_value(8'h01),
		.next_value(month_next), .wrap(month_wrap));
	bcd_step u_year (.value(year_reg), .max_value(8'h99), .min_value(8'h00),
		.next_value(year_next), .wrap());
	bcd_step u_dow (.value(dow_reg), .max_value(8'h07), .min_value(8'h01),
		.next_value(dow_next), .wrap());

	// no century exception: 00 counts as leap
	always @* begin
		leap = year_reg[4] ? (year_reg[3:0] == 4'h2 || year_reg[3:0] == 4'h6) :
			(year_reg[3:0] == 4'h0 || year_reg[3:0] == 4'h4 || year_reg[3:0] == 4'h8);
		case (month_reg)
			8'h02: date_max = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: date_max = 8'h30;
			default: date_max = 8'h31;
		endcase
	end

	always @* begin
		hour_next = hour_reg;
		hour_wrap = 1'b0;
		if (hour_reg[`RTC_HOUR_12H]) begin
			if (hour_reg[4:0] == 5'h12) begin
				hour_next[4:0] = 5'h01;
			end else if (hour_reg[4:0] == 5'h11) begin
				hour_next[4:0] = 5'h12;
				hour_next[`RTC_HOUR_PM] = ~hour_reg[`RTC_HOUR_PM];
				hour_wrap = hour_reg[`RTC_HOUR_PM];
			end else if (hour_reg[3:0] == 4'h9) begin
				hour_next[4:0] = 5'h10;
			end else begin
				hour_next[3:0] = hour_reg[3:0] + 4'h1;
			end
		end else begin
			if (hour_reg[5:0] == 6'h23) begin
				hour_next[5:0] = 6'h00;
				hour_wrap = 1'b1;
			end else if (hour_reg[3:0] == 4'h9) begin
				hour_next[5:0] = {hour_reg[5:4] + 2'h1, 4'h0};
			end else begin
				hour_next[3:0] = hour_reg[3:0] + 4'h1;
			end
		end
	end

	always @* begin
		case ({rate_select_hi, rate_select_lo})
			`RTC_RS_1HZ: sq_wave = pre_reg[DIV_BITS-1];
			`RTC_RS_4K:  sq_wave = pre_reg[2];
			`RTC_RS_8K:  sq_wave = pre_reg[1];
			default:     sq_wave = xtal_s2;
		endcase
	end

	// crystal and power pins cross into aclk through two flops
	always @(posedge aclk) begin
		if (!aresetn) begin
			xtal_s1 <= 1'b0;
			xtal_s2 <= 1'b0;
			xtal_s3 <= 1'b0;
			pwr_s1  <= 1'b0;
			pwr_s2  <= 1'b0;
		end else begin
			xtal_s1 <= crystal_in;
			xtal_s2 <= xtal_s1;
			xtal_s3 <= xtal_s2;
			pwr_s1  <= main_power_good;
			pwr_s2  <= pwr_s1;
		end
	end

	// prescaler, tick request, battery flag, square wave; a tick clashing with a host write waits a cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			pre_reg             <= {DIV_BITS{1'b0}};
			tick_pending_reg    <= 1'b0;
			on_battery          <= 1'b0;
			square_wave_out_pin <= 1'b0;
		end else begin
			on_battery <= ~pwr_s2;
			if (xtal_rise && !oscillator_stop_bit) begin
				pre_reg <= pre_reg + 1'b1;
			end
			if (tick) begin
				tick_pending_reg <= 1'b1;
			end else if (advance) begin
				tick_pending_reg <= 1'b0;
			end
			square_wave_out_pin <= square_wave_enable_bit ?
				(sq_wave & ~oscillator_stop_bit) : ctrl_reg[`RTC_CTRL_LEVEL];
		end
	end

	// time, control and storage registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			sec_reg   <= `RTC_RST_SEC;
			min_reg   <= `RTC_RST_MIN;
			hour_reg  <= `RTC_RST_HOUR;
			dow_reg   <= `RTC_RST_DOW;
			date_reg  <= `RTC_RST_DATE;
			month_reg <= `RTC_RST_MONTH;
			year_reg  <= `RTC_RST_YEAR;
			ctrl_reg  <= `RTC_RST_CTRL;
			for (i = 0; i < `RTC_RAM_DEPTH; i = i + 1) begin
				ram_reg[i] <= `RTC_RST_RAM;
			end
		end else if (write_ok) begin
			case (aw_idx_reg)
				`RTC_IDX_SEC:   sec_reg   <= w_data_reg;
				`RTC_IDX_MIN:   min_reg   <= {1'b0, w_data_reg[6:0]};
				`RTC_IDX_HOUR:  hour_reg  <= {1'b0, w_data_reg[6:0]};
				`RTC_IDX_DOW:   dow_reg   <= {5'h00, w_data_reg[2:0]};
				`RTC_IDX_DATE:  date_reg  <= {2'h0, w_data_reg[5:0]};
				`RTC_IDX_MONTH: month_reg <= {3'h0, w_data_reg[4:0]};
				`RTC_IDX_YEAR:  year_reg  <= w_data_reg;
				`RTC_IDX_CTRL:  ctrl_reg  <= w_data_reg & `RTC_CTRL_MASK;
				default:        ram_reg[ram_wr_idx] <= w_data_reg;
			endcase
		end else if (advance) begin
			sec_reg[6:0] <= sec_next[6:0];
			if (sec_wrap) begin
				min_reg <= min_next;
				if (min_wrap) begin
					hour_reg <= hour_next;
					if (hour_wrap) begin
						date_reg <= date_next;
						dow_reg  <= dow_next;
						if (date_wrap) begin
							month_reg <= month_next;
							if (month_wrap) begin
								year_reg <= year_next;
							end
						end
					end
				end
			end
		end
	end

	always @* begin
		case (ar_idx)
			`RTC_IDX_SEC:   rd_byte = sec_reg;
			`RTC_IDX_MIN:   rd_byte = min_reg;
			`RTC_IDX_HOUR:  rd_byte = hour_reg;
			`RTC_IDX_DOW:   rd_byte = dow_reg;
			`RTC_IDX_DATE:  rd_byte = date_reg;
			`RTC_IDX_MONTH: rd_byte = month_reg;
			`RTC_IDX_YEAR:  rd_byte = year_reg;
			`RTC_IDX_CTRL:  rd_byte = ctrl_reg;
			default:        rd_byte = ram_reg[ram_rd_idx];
		endcase
	end

	// axi4-lite: address and data taken in either order, one response after both
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_idx_reg   <= 6'h00;
			aw_held_reg  <= 1'b0;
			w_data_reg   <= 8'h00;
			w_held_reg   <= 1'b0;
			w_lane_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AXI_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp  <= `AXI_RESP_OKAY;
			s_axi_rdata  <= 32'h00000000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx_reg  <= s_axi_awaddr[7:2];
				aw_held_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata[7:0];
				w_lane_reg <= s_axi_wstrb[0];
				w_held_reg <= 1'b1;
			end
			if (do_write) begin
				aw_held_reg  <= 1'b0;
				w_held_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= on_battery ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `AXI_RESP_OKAY;
				s_axi_rdata  <= {24'h000000, rd_byte};
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // rtc_calendar
`default_nettype wire

// ---- shared/rtc_defs.vh ----
// register indices, field positions, reset values and timing constants of the clock/calendar
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

`define RTC_IDX_SEC       6'h00
`define RTC_IDX_MIN       6'h01
`define RTC_IDX_HOUR      6'h02
`define RTC_IDX_DOW       6'h03
`define RTC_IDX_DATE      6'h04
`define RTC_IDX_MONTH     6'h05
`define RTC_IDX_YEAR      6'h06
`define RTC_IDX_CTRL      6'h07
`define RTC_IDX_RAM_FIRST 6'h08
`define RTC_RAM_DEPTH     56
`define RTC_IDX_BITS      6

`define RTC_SEC_OSC_STOP  7
`define RTC_HOUR_12H      6
`define RTC_HOUR_PM       5
`define RTC_CTRL_LEVEL    7
`define RTC_CTRL_SQ_EN    4
`define RTC_CTRL_RS_HI    1
`define RTC_CTRL_RS_LO    0
`define RTC_CTRL_MASK     8'h93

`define RTC_RST_SEC       8'h00
`define RTC_RST_MIN       8'h00
`define RTC_RST_HOUR      8'h00
`define RTC_RST_DOW       8'h01
`define RTC_RST_DATE      8'h01
`define RTC_RST_MONTH     8'h01
`define RTC_RST_YEAR      8'h00
`define RTC_RST_CTRL      8'h03
`define RTC_RST_RAM       8'h00

`define RTC_RS_1HZ        2'b00
`define RTC_RS_4K         2'b01
`define RTC_RS_8K         2'b10
`define RTC_RS_32K        2'b11

// crystal edges per second: 32768 = 2**15
`define RTC_DIV_BITS      15

`define AXI_RESP_OKAY     2'b00
`define AXI_RESP_SLVERR   2'b10

`endif

// ---- hw/bcd_step.v ----
// one bcd counter field: next value and wrap flag
`timescale 1ns/1ns
`default_nettype none
module bcd_step (
	input  wire [7:0] value,
	input  wire [7:0] max_value,
	input  wire [7:0] min_value,
	output reg  [7:0] next_value,
	output reg        wrap
);
	always @* begin
		wrap = (value == max_value);
		if (wrap) begin
			next_value = min_value;
		end else if (value[3:0] == 4'h9) begin
			next_value = {value[7:4] + 4'h1, 4'h0};
		end else begin
			next_value = {value[7:4], value[3:0] + 4'h1};
		end
	end
endmodule // bcd_step
`default_nettype wire

// ---- tb/crystal_model.sv ----
// free-running crystal source for the clock/calendar bench
`timescale 1ns/1ns
`default_nettype none
module crystal_model (
	output logic crystal_in
);
	// a crystal has no frames, so it runs free; the offset keeps it off the bus clock phase
	initial begin
		crystal_in = 1'b0;
		#7;
		forever #80 crystal_in = ~crystal_in;
	end
endmodule // crystal_model
`default_nettype wire

// ---- tb/rtc_calendar_assertions.sv ----
// register bus and battery checks for the clock/calendar
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defs.vh"
module rtc_calendar_chk (
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	input wire logic	on_battery
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && s_axi_rresp == 2'b00) else $error("read not answered");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
	a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_battery_refuse: assert property ($rose(s_axi_bvalid) && $past(on_battery) &&
		on_battery |-> s_axi_bresp == `AXI_RESP_SLVERR) else $error("battery write accepted");
endmodule // rtc_calendar_chk
bind rtc_calendar rtc_calendar_chk chk (.*);
`default_nettype wire

// ---- tb/rtc_calendar_test.sv ----
// self-checking bench for the bcd clock/calendar
`timescale 1ns/1ns
`default_nettype none
`include "rtc_defs.vh"
module rtc_calendar_test;
	localparam logic [1:0] okay = `AXI_RESP_OKAY;
	logic		aclk = 1'b0, aresetn = 1'b0, main_power_good = 1'b1;
	logic		s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic		s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0]	s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
	logic [31:0]	s_axi_wdata = 32'h00000000;
	logic [3:0]	s_axi_wstrb = 4'hF;
	wire logic	s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic	crystal_in, square_wave_out_pin, on_battery;
	wire logic [1:0]	s_axi_bresp, s_axi_rresp;
	wire logic [31:0]	s_axi_rdata;
	int		n_fail = 0;
	int		n_checks = 0;
	int		c;
	crystal_model xm (.crystal_in(crystal_in));
	// short prescaler: one second is 16 crystal edges, 128 bus clocks
	rtc_calendar #(.DIV_BITS(4)) uut (.*);
	initial begin
		forever #10 aclk = ~aclk;
	end
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task hang(input int k);
		if (k >= 50) begin
			chk("handshake", 1'b0, 1'b1);
			stop_test;
		end
	endtask
	task wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] e);
		int k;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 50);
		s_axi_bready <= 1'b0;
		hang(k);
		chk("write response", s_axi_bresp, e);
	endtask
	task rd(input logic [5:0] i);
		int k;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do begin
			@(posedge aclk);
			k++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 50);
		s_axi_rready <= 1'b0;
		v = s_axi_rdata[7:0];
		hang(k);
	endtask
	task rises(input int n);
		logic p;
		c = 0;
		p = square_wave_out_pin;
		repeat (n) begin
			@(posedge aclk);
			if (square_wave_out_pin && !p) c++;
			p = square_wave_out_pin;
		end
	endtask
	task t_reset;
		logic [7:0] e [8];
		e = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03};
		for (int i = 0; i < 8; i++) begin
			rd(i[5:0]);
			chk("reset value", v, e[i]);
		end
		rd(6'h3F);
		chk("storage reset", v, 8'h00);
		chk("pin after reset", square_wave_out_pin, 1'b0);
		$display("test reset done");
	endtask
	task t_ram;
		wr(6'h08, 8'hA5, okay);
		wr(6'h3F, 8'h5A, okay);
		rd(6'h08);
		chk("storage first", v, 8'hA5);
		rd(6'h3F);
		chk("storage last", v, 8'h5A);
		s_axi_wstrb <= 4'h0;
		wr(6'h08, 8'h11, okay);
		s_axi_wstrb <= 4'hF;
		rd(6'h08);
		chk("lane off", v, 8'hA5);
		wr(6'h07, 8'hFF, okay);
		rd(6'h07);
		chk("control mask", v, 8'h93);
		$display("test storage done");
	endtask
	task t_sqw;
		int e [4];
		e = '{2, 4, 8, 32};
		wr(6'h07, 8'h80, okay);
		repeat (8) @(posedge aclk);
		chk("static high", square_wave_out_pin, 1'b1);
		wr(6'h07, 8'h00, okay);
		repeat (8) @(posedge aclk);
		chk("static low", square_wave_out_pin, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(6'h07, 8'h10 | i[7:0], okay);
			rises(256);
			chk("rate rises", c >= e[i] - 1 && c <= e[i] + 1, 1'b1);
		end
		$display("test square wave done");
	endtask
	task t_stop;
		wr(6'h00, 8'hB0, okay);
		repeat (8) @(posedge aclk);
		rises(160);
		chk("stopped wave", c, 0);
		rd(6'h00);
		chk("seconds frozen", v, 8'hB0);
		wr(6'h00, 8'h30, okay);
		repeat (300) @(posedge aclk);
		rd(6'h00);
		chk("seconds counted", v == 8'h32 || v == 8'h33, 1'b1);
		$display("test oscillator done");
	endtask
	task t_roll;
		logic [7:0] t [5][10];
		t = '{'{8'h23, 8'h07, 8'h28, 8'h02, 8'h04, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04},
			'{8'h23, 8'h03, 8'h28, 8'h02, 8'h01, 8'h00, 8'h04, 8'h01, 8'h03, 8'h01},
			'{8'h23, 8'h01, 8'h30, 8'h04, 8'h10, 8'h00, 8'h02, 8'h01, 8'h05, 8'h10},
			'{8'h23, 8'h02, 8'h31, 8'h12, 8'h99, 8'h00, 8'h03, 8'h01, 8'h01, 8'h00},
			'{8'h71, 8'h05, 8'h29, 8'h02, 8'h00, 8'h52, 8'h06, 8'h01, 8'h03, 8'h00}};
		for (int i = 0; i < 5; i++) begin
			// stop counting while the fields are loaded, then start at 59 seconds
			wr(6'h00, 8'hD9, okay);
			wr(6'h01, 8'h59, okay);
			for (int j = 0; j < 5; j++) wr(6'(j + 2), t[i][j], okay);
			wr(6'h00, 8'h59, okay);
			repeat (200) @(posedge aclk);
			rd(6'h01);
			chk("minute carry", v, 8'h00);
			for (int j = 0; j < 5; j++) begin
				rd(6'(j + 2));
				chk("calendar carry", v, t[i][j + 5]);
			end
		end
		$display("test rollover done");
	endtask
	task t_batt;
		main_power_good <= 1'b0;
		repeat (8) @(posedge aclk);
		chk("on battery", on_battery, 1'b1);
		wr(6'h09, 8'h77, `AXI_RESP_SLVERR);
		rd(6'h09);
		chk("storage kept", v, 8'h00);
		main_power_good <= 1'b1;
		repeat (8) @(posedge aclk);
		chk("main power", on_battery, 1'b0);
		$display("test battery done");
	endtask
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_ram;
		t_sqw;
		t_stop;
		t_roll;
		t_batt;
		stop_test;
	end
	initial begin
		#2000000;
		chk("run time", 1'b0, 1'b1);
		stop_test;
	end
endmodule // rtc_calendar_test
`default_nettype wire
